// [src/seq_cfg_consts.vh]
`ifndef SEQ_CFG_CONSTS_VH
`define SEQ_CFG_CONSTS_VH
// register addresses
`define ADDR_SEQ_CFG      15'h000B
`define ADDR_CELL1_Z      15'h0111
`define ADDR_CELL0_Z      15'h0112
`define ADDR_CELL1_X      15'h0113
`define ADDR_CELL0_X      15'h0114
`define ADDR_LIN_POS      15'h0122
// frame layout
`define FRAME_BITS        6'h20
`define ADDR_BITS         6'h10
`define WRITE_BIT         15
// configuration fields
`define FLD_RANGE_EXT     11
`define FLD_COORD_SIGN    10
`define FLD_TABLE_HI      6
`define FLD_TABLE_LO      7
`define FLD_MAGNET_DIR    5
`define FLD_DIFF_MEAS     4
`define FLD_READY_TRI     1
`define CFG_RESET         16'h0000
`define CFG_WRITE_MASK    16'h0CF2
// sample periods in microseconds and cycles at 100 MHz
`define CLK_MHZ           100
`define PERIOD_1K_US      1000
`define PERIOD_05K_US     2000
`define CYC_1K_LAST       18'h1869F
`define CYC_05K_LAST      18'h30D3F
`endif

// [src/sequencer_mode_config.v]
`timescale 1ns/1ps
`include "seq_cfg_consts.vh"
module sequencer_mode_config
#(
	// last count of each sample period
	parameter [17:0] LAST_1K  = `CYC_1K_LAST,
	parameter [17:0] LAST_05K = `CYC_05K_LAST
)
(
	// clock and reset
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	// spi pins
	input  wire        sck_i,
	input  wire        cs_n_i,
	input  wire        mosi_i,
	output reg         miso_o,
	output reg         miso_oe_o,
	// ready pin
	output reg         ready_o,
	output reg         ready_oe_o,
	// measurement inputs
	input  wire [15:0] cell0_z_field_i,
	input  wire [15:0] cell1_z_field_i,
	input  wire [15:0] cell0_x_field_i,
	input  wire [15:0] cell1_x_field_i,
	input  wire [15:0] lin_raw_i,
	input  wire [15:0] lin_ext_i,
	// datapath controls
	output reg  [15:0] vec_z_o,
	output reg  [15:0] vec_x_o,
	output reg         sample_o,
	output reg  [15:0] lin_pos_o,
	output reg  [1:0]  table_sel_o,
	output reg         magnet_orientation_o,
	output reg         differential_measure_o
);
	// pin synchronisers
	reg  [1:0]  sck_s_q;
	reg  [1:0]  cs_s_q;
	reg  [1:0]  mosi_s_q;
	reg         sck_prev_q;
	reg  [15:0] cfg_q;
	reg  [5:0]  bit_cnt_q;
	reg  [15:0] addr_q;
	reg  [15:0] shin_q;
	reg  [15:0] shout_q;
	reg  [17:0] smp_cnt_q;
	reg         data_ready_q;
	wire        sck_rise;
	wire        cs_act;
	wire [15:0] rd_val;
	wire [15:0] lin_sel;
	wire [15:0] lin_fin;
	wire [17:0] period;
	wire [15:0] new_word;
	wire        range_extension_enable;
	wire        coordinate_sign_select;
	wire        ready_tristate;
	reg  [15:0] read_mux;

	assign sck_rise = sck_s_q[1] & ~sck_prev_q;
	assign cs_act = ~cs_s_q[1];
	assign range_extension_enable = cfg_q[`FLD_RANGE_EXT];
	assign coordinate_sign_select = cfg_q[`FLD_COORD_SIGN];
	assign ready_tristate = cfg_q[`FLD_READY_TRI];
	assign lin_sel = range_extension_enable ? lin_ext_i : lin_raw_i;
	assign lin_fin = (coordinate_sign_select & cfg_q[`FLD_MAGNET_DIR]) ?
		(~lin_sel + 16'h0001) : lin_sel;
	assign period = cfg_q[`FLD_TABLE_LO] ? LAST_05K : LAST_1K;
	assign new_word = {shin_q[14:0], mosi_s_q[1]};

	always @*
	begin
		case (new_word[14:0])
			`ADDR_SEQ_CFG: read_mux = cfg_q;
			`ADDR_CELL1_Z: read_mux = cell1_z_field_i;
			`ADDR_CELL0_Z: read_mux = cell0_z_field_i;
			`ADDR_CELL1_X: read_mux = cell1_x_field_i;
			`ADDR_CELL0_X: read_mux = cell0_x_field_i;
			`ADDR_LIN_POS: read_mux = lin_pos_o;
			default:       read_mux = 16'h0000;
		endcase
	end
	assign rd_val = read_mux;

	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			sck_s_q <= 2'h0;
			cs_s_q <= 2'h3;
			mosi_s_q <= 2'h0;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			sck_s_q <= {sck_s_q[0], sck_i};
			cs_s_q <= {cs_s_q[0], cs_n_i};
			mosi_s_q <= {mosi_s_q[0], mosi_i};
			sck_prev_q <= sck_s_q[1];
		end
	end

	// spi frame engine
	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg_q <= `CFG_RESET;
			bit_cnt_q <= 6'h00;
			addr_q <= 16'h0000;
			shin_q <= 16'h0000;
			shout_q <= 16'h0000;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end
		else
		begin
			miso_oe_o <= cs_act;
			if (!cs_act)
				bit_cnt_q <= 6'h00;
			else if (sck_rise)
			begin
				shin_q <= new_word;
				miso_o <= shout_q[15];
				shout_q <= {shout_q[14:0], 1'b0};
				if (bit_cnt_q == `ADDR_BITS - 6'h01)
				begin
					addr_q <= new_word;
					shout_q <= rd_val;
					bit_cnt_q <= bit_cnt_q + 6'h01;
				end
				else if (bit_cnt_q == `FRAME_BITS - 6'h01)
				begin
					if (addr_q[`WRITE_BIT] && addr_q[14:0] == `ADDR_SEQ_CFG)
						cfg_q <= new_word & `CFG_WRITE_MASK;
					shout_q <= addr_q;
					bit_cnt_q <= 6'h00;
				end
				else
					bit_cnt_q <= bit_cnt_q + 6'h01;
			end
		end
	end

	// sequencer timing and table inputs
	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			smp_cnt_q <= 18'h00000;
			sample_o <= 1'b0;
			vec_z_o <= 16'h0000;
			vec_x_o <= 16'h0000;
			lin_pos_o <= 16'h0000;
			data_ready_q <= 1'b0;
			table_sel_o <= 2'h0;
			magnet_orientation_o <= 1'b0;
			differential_measure_o <= 1'b0;
		end
		else
		begin
			table_sel_o <= {cfg_q[`FLD_TABLE_HI], cfg_q[`FLD_TABLE_LO]};
			magnet_orientation_o <= cfg_q[`FLD_MAGNET_DIR];
			differential_measure_o <= cfg_q[`FLD_DIFF_MEAS];
			sample_o <= 1'b0;
			if (smp_cnt_q >= period)
			begin
				smp_cnt_q <= 18'h00000;
				sample_o <= 1'b1;
				lin_pos_o <= lin_fin;
				data_ready_q <= 1'b1;
				if (!cfg_q[`FLD_TABLE_HI])
				begin
					vec_z_o <= cell0_z_field_i - cell1_z_field_i;
					vec_x_o <= cell0_x_field_i - cell1_x_field_i;
				end
				else
				begin
					vec_z_o <= cell1_z_field_i;
					vec_x_o <= cell1_x_field_i;
				end
			end
			else
			begin
				smp_cnt_q <= smp_cnt_q + 18'h00001;
				if (cs_act && sck_rise && bit_cnt_q == `ADDR_BITS - 6'h01 &&
					!new_word[`WRITE_BIT] && new_word[14:0] == `ADDR_LIN_POS)
					data_ready_q <= 1'b0;
			end
		end
	end

	// ready pin drive
	always @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			ready_o <= 1'b0;
			ready_oe_o <= 1'b1;
		end
		else if (!ready_tristate)
		begin
			ready_o <= data_ready_q;
			ready_oe_o <= 1'b1;
		end
		else
		begin
			ready_o <= 1'b1;
			ready_oe_o <= cs_act & data_ready_q;
		end
	end
endmodule // sequencer_mode_config

// [test/seq_cfg_properties.sv]
`timescale 1ns/1ps
module seq_cfg_properties (
	// watched ports
	input wire        core_clk_i,
	input wire        sys_rst_i,
	input wire        cs_n_i,
	input wire        miso_oe_o,
	input wire        ready_oe_o,
	input wire        sample_o,
	input wire [1:0]  table_sel_o,
	input wire [15:0] cell0_z_field_i,
	input wire [15:0] cell1_z_field_i,
	input wire [15:0] vec_z_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_reset_val: assert property ($fell(sys_rst_i) |-> table_sel_o == 2'h0 && ready_oe_o)
		else $error("reset value");
	chk_miso_idle: assert property (cs_n_i [*6] |-> !miso_oe_o)
		else $error("miso idle");
	chk_miso_busy: assert property (!cs_n_i [*6] |-> miso_oe_o)
		else $error("miso busy");
	chk_pulse_once: assert property (sample_o |=> !sample_o)
		else $error("sample width");
	chk_cfg_quiet: assert property (cs_n_i [*8] |-> $stable(table_sel_o))
		else $error("config moved");
	chk_ready_float: assert property (cs_n_i [*8] ##0 !ready_oe_o |=> !ready_oe_o)
		else $error("ready driven");
	chk_vec_diff: assert property (sample_o && !table_sel_o[1] |->
		vec_z_o == $past(cell0_z_field_i) - $past(cell1_z_field_i)) else $error("diff vector");
	chk_vec_abs: assert property (sample_o && table_sel_o[1] |->
		vec_z_o == $past(cell1_z_field_i)) else $error("abs vector");
endmodule // seq_cfg_properties
bind sequencer_mode_config seq_cfg_properties u_props (.core_clk_i, .sys_rst_i, .cs_n_i,
	.miso_oe_o, .ready_oe_o, .sample_o, .table_sel_o, .cell0_z_field_i, .cell1_z_field_i, .vec_z_o);

// [test/spi_host.sv]
`timescale 1ns/1ps
module spi_host (
	// spi pins
	output logic      sck_o = 1'b0,
	output logic      cs_n_o = 1'b1,
	output logic      mosi_o = 1'b0,
	input  wire logic miso_i
);
	// one frame, write flag and address then data, msb first
	task automatic xfer(input logic [31:0] tx, output logic [15:0] rx);
		integer i;
		cs_n_o = 1'b0;
		for (i = 31; i >= 0; i--)
		begin
			mosi_o = tx[i];
			#60 sck_o = 1'b1;
			#60 sck_o = 1'b0;
			if (i < 16)
				rx[i] = miso_i;
		end
		mosi_o = ~mosi_o;
		#60 cs_n_o = 1'b1;
		#60;
	endtask
endmodule // spi_host

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic        core_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [15:0] lin_raw_i = 16'h0100;
	logic [15:0] rx, ev, cfg, lp;
	wire         sck_i, cs_n_i, mosi_i, miso_o, ready_oe_o, ready_o, sample_o;
	wire  [1:0]  table_sel_o;
	wire  [15:0] vec_z_o, lin_pos_o;
	integer      n_fail = 0;
	integer      n_tests = 0;
	integer      t;
	always #5 core_clk_i = ~core_clk_i;
	spi_host u_host (.sck_o(sck_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i), .miso_i(miso_o));
	sequencer_mode_config #(.LAST_1K(18'h003E7), .LAST_05K(18'h007CF))
		u_dut (.core_clk_i, .sys_rst_i, .sck_i, .cs_n_i, .mosi_i, .miso_o,
		.miso_oe_o(), .ready_o, .ready_oe_o, .cell0_z_field_i(16'h0500),
		.cell1_z_field_i(16'h0100), .cell0_x_field_i(16'h0700), .cell1_x_field_i(16'h0200),
		.lin_raw_i, .lin_ext_i(16'h0456), .vec_z_o, .vec_x_o(), .sample_o, .lin_pos_o,
		.table_sel_o, .magnet_orientation_o(), .differential_measure_o());
	task chk(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want)
		begin
			n_fail++;
			$display("[ERR] %0t %h %h", $time, got, want);
		end
	endtask
	task give_verdict;
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#400000 n_fail++;
		give_verdict;
	end
	initial
	begin
		repeat (5) @(posedge core_clk_i);
		#1 sys_rst_i = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#1 u_host.xfer({1'b0, 15'h000B, 16'h0000}, rx);
		chk(rx, 16'h0000);
		for (t = 0; t < 4; t++)
		begin
			cfg = {4'h0, !t[1], 3'h4, t[0], t[1], t[0], !t[1], 2'h0, t[0], 1'b0};
			lin_raw_i = lin_raw_i + 16'h0011;
			u_host.xfer({1'b1, 15'h000B, cfg}, rx);
			@(posedge sample_o);
			#1 u_host.xfer({1'b0, 15'h000B, 16'h0000}, rx);
			chk(rx, cfg);
			chk(table_sel_o, t[1:0]);
			chk(vec_z_o, t[1] ? 16'h0100 : 16'h0400);
			ev = t[1] ? lin_raw_i : 16'h0456;
			lp = t[0] ? -ev : ev;
			chk(lin_pos_o, lp);
			chk(ready_o, 1'b1);
			chk(ready_oe_o, !t[0]);
			u_host.xfer({1'b0, 15'h0122, 16'h0000}, rx);
			chk(rx, lp);
			chk(ready_o, t[0]);
		end
		give_verdict;
	end
endmodule // testbench
